// >>> shared/bfd_defines.vh
// Register map, field positions, reset values and timing for breaker failure
`ifndef BFD_DEFINES_VH
`define BFD_DEFINES_VH
// Register indexes inside one unit window (byte address = 4 * index)
`define BFD_IDX_CTRL      4'h0
`define BFD_IDX_PH_SUPV   4'h1
`define BFD_IDX_N_SUPV    4'h2
`define BFD_IDX_PH_HI     4'h3
`define BFD_IDX_N_HI      4'h4
`define BFD_IDX_PH_LO     4'h5
`define BFD_IDX_N_LO      4'h6
`define BFD_IDX_T1        4'h7
`define BFD_IDX_T2        4'h8
`define BFD_IDX_T3        4'h9
`define BFD_IDX_LO_DLY    4'ha
`define BFD_IDX_HOLD      4'hb
`define BFD_IDX_STATUS    4'hc
`define BFD_NUM_CFG       12
// Unit windows and shared interrupt registers (byte addresses)
`define BFD_UNIT0_BASE    8'h00
`define BFD_UNIT1_BASE    8'h40
`define BFD_IRQ_STAT      8'h80
`define BFD_IRQ_CLR       8'h84
`define BFD_IRQ_EN        8'h88
// Control register fields
`define BFD_CTRL_FUNC     0
`define BFD_CTRL_1POLE    1
`define BFD_CTRL_AMP      2
`define BFD_CTRL_SEAL     3
`define BFD_CTRL_EARLY    4
`define BFD_CTRL_MAIN     5
`define BFD_CTRL_SLOW     6
`define BFD_CTRL_MASK     16'h007f
// Reset values
`define BFD_CTRL_RST      16'h007c
`define BFD_THR_RST       16'h041a
`define BFD_DLY_RST       16'h0000
`define BFD_IRQ_EN_RST    4'h0
// Timing: delays count a 1 ms tick taken from a 10 ns clock
`define BFD_TICK_NS       1000000
`define BFD_CLK_NS        10
`endif

// >>> logic/bfd_top.v
// Dual breaker failure detection units with APB register slave
//
// Overview of operation
// [RULE1] Two identical independent breaker failure units
// [RULE2] Mode selects three-pole or single-pole variant
// [RULE3] Scheme starts on the initiate input
// [RULE4] Seal-in holds initiate while current supervised
// [RULE5] Optional current supervision gates the initiate
// [RULE6] Accepted initiate re-trips breaker at once
// [RULE7] Three delayed paths declare failure, zone trip
// [RULE8] Each path has its own enable
// [RULE9] Early path needs closed aux contact, current
// [RULE10] Main path needs only fault current
// [RULE11] High-set after timeout, then low-set after delay
// [RULE12] Detectors examined only after path delay
// [RULE13] Delays 0 to 65.535 s, paths default on
// [RULE14] Thresholds 0.001 to 30 pu, default 1.050
// [RULE15] Inhibit input halts scheme and seal-in
// [RULE16] Slow path: aux contact, in service, no current
// [RULE17] Zone trip held for programmable dropout period
// [RULE18] Timers count 1 ms tick, clear when idle
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`include "bfd_defines.vh"

module bfd_top #(
   parameter MS_CYCLES = `BFD_TICK_NS / `BFD_CLK_NS,
   parameter UNITS     = 2
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [31:0] phase_amp,
   input  wire [31:0] neutral_amp,
   input  wire [1:0]  three_pole_initiate_in,
   input  wire [1:0]  scheme_inhibit_in,
   input  wire [1:0]  fast_aux_contact_in,
   input  wire [1:0]  normal_aux_contact_in,
   input  wire [1:0]  out_of_service_in,
   output wire [1:0]  retrip_out,
   output wire [1:0]  zone_trip_out,
   output reg         irq
);

   // Trip hold states
   localparam S_IDLE = 3'b001;
   localparam S_TRIP = 3'b010;
   localparam S_HOLD = 3'b100;

   // Register file and shared interrupt state
   reg  [15:0] cfg_q [0:31];
   reg  [16:0] tick_cnt_q;
   reg         tick_q;
   reg  [3:0]  irq_stat_q;
   reg  [3:0]  irq_en_q;
   reg  [31:0] rd_d;
   reg         err_d;
   reg  [3:0]  irq_stat_d;
   wire [23:0] unit_stat;
   wire [3:0]  unit_ev;
   // Bus decode: access cycle awaiting its answer, and completing cycle
   wire        acc      = psel & penable & ~pready;
   wire        done     = psel & penable & pready;
   wire        is_unit  = ~paddr[7];
   wire [3:0]  idx      = paddr[5:2];
   wire [4:0]  cfg_idx  = {paddr[6], paddr[5:2]};
   integer     k;

   ////////////////////////////////////////////////////////////////////////
   // Saturating count used by every millisecond timer
   function [15:0] bump;
      input [15:0] c;
      input        t;
      begin
         bump = (t && c != 16'hffff) ? c + 16'h0001 : c;
      end
   endfunction

   // Reset value of a configuration word by its index
   function [15:0] cfg_rst;
      input [3:0] i;
      begin
         if (i == `BFD_IDX_CTRL)
            cfg_rst = `BFD_CTRL_RST; // RULE13
         else if (i <= `BFD_IDX_N_LO)
            cfg_rst = `BFD_THR_RST; // RULE14
         else
            cfg_rst = `BFD_DLY_RST;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Millisecond tick shared by all timers
   // Free-running, so a delay of N ms elapses after N-1 to N ms
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 17'h00000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == MS_CYCLES[16:0] - 17'h00001) begin
         tick_cnt_q <= 17'h00000;
         tick_q     <= 1'b1; // RULE18
      end else begin
         tick_cnt_q <= tick_cnt_q + 17'h00001;
         tick_q     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-unit detection logic
   // Each unit owns its settings window, its pins and its status bits
   genvar i;
   generate
      for (i = 0; i < UNITS; i = i + 1) begin : g_unit // RULE1
         // Named views of this unit's configuration words
         wire [15:0] ctrl  = cfg_q[i*16+`BFD_IDX_CTRL];
         wire [15:0] phase_supervision_threshold;
         wire [15:0] neutral_supervision_threshold;
         wire [15:0] phase_high_threshold;
         wire [15:0] neutral_high_threshold;
         wire [15:0] phase_low_threshold;
         wire [15:0] neutral_low_threshold;
         wire [15:0] early_path_delay;
         wire [15:0] main_path_delay;
         wire [15:0] slow_path_delay;
         wire [15:0] low_set_delay;
         wire [15:0] trip_hold_period;
         assign phase_supervision_threshold   = cfg_q[i*16+`BFD_IDX_PH_SUPV];
         assign neutral_supervision_threshold = cfg_q[i*16+`BFD_IDX_N_SUPV];
         assign phase_high_threshold          = cfg_q[i*16+`BFD_IDX_PH_HI];
         assign neutral_high_threshold        = cfg_q[i*16+`BFD_IDX_N_HI];
         assign phase_low_threshold           = cfg_q[i*16+`BFD_IDX_PH_LO];
         assign neutral_low_threshold         = cfg_q[i*16+`BFD_IDX_N_LO];
         assign early_path_delay              = cfg_q[i*16+`BFD_IDX_T1];
         assign main_path_delay               = cfg_q[i*16+`BFD_IDX_T2];
         assign slow_path_delay               = cfg_q[i*16+`BFD_IDX_T3];
         assign low_set_delay                 = cfg_q[i*16+`BFD_IDX_LO_DLY];
         assign trip_hold_period              = cfg_q[i*16+`BFD_IDX_HOLD];

         wire [15:0] ph    = phase_amp[i*16 +: 16];
         wire [15:0] nu    = neutral_amp[i*16 +: 16];
         // Initiate only counts while the unit is enabled and unblocked
         wire        run   = ctrl[`BFD_CTRL_FUNC] & ~scheme_inhibit_in[i];
         // Neutral supervision only means something for three-pole use
         wire        n_use = ~ctrl[`BFD_CTRL_1POLE]; // RULE2
         // Supervision: phase or neutral strictly above its level
         wire        supv  = (ph > phase_supervision_threshold)
                           | (n_use & (nu > neutral_supervision_threshold));
         wire        start = run & three_pole_initiate_in[i]; // RULE3
         // Path progress and decision nets
         wire        accept;
         wire        active;
         wire        t1_done;
         wire        t2_done;
         wire        t3_done;
         wire        lo_run;
         wire        lo_done;
         wire        detect;
         wire        f_early;
         wire        f_main;
         wire        f_slow;
         wire        fail;
         wire        hold_done;
         // Per-unit state
         reg         seal_q;
         reg         retrip_q;
         reg         trip_q;
         reg  [2:0]  state_q;
         reg  [15:0] t1_q;
         reg  [15:0] t2_q;
         reg  [15:0] t3_q;
         reg  [15:0] lo_q;
         reg  [15:0] hold_q;

         // Supervised initiate is refused while current is low
         assign accept = start & (~ctrl[`BFD_CTRL_AMP] | supv); // RULE5
         // Inhibit drops the sealed initiate as well
         assign active = run & (accept | seal_q); // RULE15

         // Seal-in survives a fast reset of the protection trip
         // It only sets while current is above the supervision level
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               seal_q <= 1'b0;
            else if (!run)
               seal_q <= 1'b0; // RULE15
            else if (accept & ctrl[`BFD_CTRL_SEAL] & supv)
               seal_q <= 1'b1; // RULE4
            else if (!supv)
               seal_q <= 1'b0; // RULE4
         end

         // Re-trip follows the scheme, no timer involved
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               retrip_q <= 1'b0;
            else
               retrip_q <= active; // RULE6
         end

         // Path timers run only while the scheme is active
         // Counts saturate so a long failure never wraps to a short one
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               t1_q <= 16'h0000;
               t2_q <= 16'h0000;
               t3_q <= 16'h0000;
               lo_q <= 16'h0000;
            end else begin
               t1_q <= active ? bump(t1_q, tick_q) : 16'h0000; // RULE18
               t2_q <= active ? bump(t2_q, tick_q) : 16'h0000; // RULE18
               t3_q <= active ? bump(t3_q, tick_q) : 16'h0000; // RULE18
               lo_q <= lo_run ? bump(lo_q, tick_q) : 16'h0000; // RULE11
            end
         end

         // A path is due once its count reaches its setting
         assign t1_done = active & (t1_q >= early_path_delay); // RULE13
         assign t2_done = active & (t2_q >= main_path_delay); // RULE13
         assign t3_done = active & (t3_q >= slow_path_delay); // RULE13
         // Low-set delay starts with the first early or main timeout
         assign lo_run  = (t1_done & ctrl[`BFD_CTRL_EARLY])
                        | (t2_done & ctrl[`BFD_CTRL_MAIN]); // RULE11
         assign lo_done = lo_run & (lo_q >= low_set_delay); // RULE11
         // Detectors are looked at only behind the path delay
         assign detect  = lo_run & (lo_done ?
                          ((ph > phase_low_threshold) |
                           (n_use & (nu > neutral_low_threshold))) :
                          ((ph > phase_high_threshold) |
                           (n_use & (nu > neutral_high_threshold)))); // RULE12
         // Early path also needs the breaker still showing closed
         assign f_early = ctrl[`BFD_CTRL_EARLY] & t1_done
                        & fast_aux_contact_in[i] & detect; // RULE9
         // Main path ignores the contacts: a pole may open yet still arc
         assign f_main  = ctrl[`BFD_CTRL_MAIN] & t2_done & detect; // RULE10
         // Slow path catches low faults, so no current check here
         assign f_slow  = ctrl[`BFD_CTRL_SLOW] & t3_done
                        & normal_aux_contact_in[i]
                        & ~out_of_service_in[i]; // RULE16
         // Any enabled path declares the failure
         assign fail    = f_early | f_main | f_slow; // RULE7 RULE8

         // Hold reached; a zero setting releases right after the failure
         assign hold_done = hold_q >= trip_hold_period; // RULE17

         // Zone trip with dropout hold after the failure clears
         // A new failure during the hold restarts the full hold period
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               state_q <= S_IDLE;
               trip_q  <= 1'b0;
               hold_q  <= 16'h0000;
            end else begin
               case (state_q)
                  S_IDLE: begin
                     hold_q <= 16'h0000;
                     if (fail) begin
                        state_q <= S_TRIP; // RULE7
                        trip_q  <= 1'b1;
                     end
                  end
                  S_TRIP: begin
                     hold_q <= 16'h0000;
                     if (!fail)
                        state_q <= S_HOLD;
                  end
                  S_HOLD: begin
                     if (fail) begin
                        state_q <= S_TRIP;
                        hold_q  <= 16'h0000;
                     end else if (hold_done) begin
                        state_q <= S_IDLE; // RULE17
                        trip_q  <= 1'b0;
                        hold_q  <= 16'h0000;
                     end else begin
                        hold_q <= bump(hold_q, tick_q); // RULE18
                     end
                  end
                  default: begin
                     state_q <= S_IDLE;
                     trip_q  <= 1'b0;
                     hold_q  <= 16'h0000;
                  end
               endcase
            end
         end

         // Outputs come straight from the unit's flip-flops
         assign retrip_out[i]    = retrip_q;
         assign zone_trip_out[i] = trip_q;
         // Events: re-trip start in bits 0 and 1, first failure in 2 and 3
         assign unit_ev[i]       = active & ~retrip_q;
         assign unit_ev[2+i]     = fail & (state_q == S_IDLE);
         // Live status word, read through the unit's status index
         assign unit_stat[i*12 +: 12] = {f_slow, f_main, f_early, detect,
                                         lo_done, t3_done, t2_done,
                                         t1_done, seal_q, active, trip_q,
                                         retrip_q};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read decode and unmapped address check
   // Only the low 16, 12 or 4 bits carry data; upper bits read as zero
   always @* begin
      rd_d  = 32'h00000000;
      err_d = 1'b0;
      if (is_unit) begin
         if (idx < `BFD_NUM_CFG)
            rd_d = {16'h0000, cfg_q[cfg_idx]};
         else if (idx == `BFD_IDX_STATUS)
            rd_d = {20'h00000, unit_stat[paddr[6]*12 +: 12]};
         else
            err_d = 1'b1;
      end else if (paddr == `BFD_IRQ_STAT)
         rd_d = {28'h0000000, irq_stat_q};
      else if (paddr == `BFD_IRQ_EN)
         rd_d = {28'h0000000, irq_en_q};
      else if (paddr != `BFD_IRQ_CLR)
         err_d = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky events: a new event wins over a clear in the same cycle
   always @* begin
      irq_stat_d = irq_stat_q | unit_ev;
      if (done & pwrite & ~pslverr & (paddr == `BFD_IRQ_CLR))
         irq_stat_d = (irq_stat_q & ~pwdata[3:0]) | unit_ev;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, answer registered
   // Registered answer, so pready never stands a second cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= acc;
         pslverr <= acc & err_d;
         // Write data is never echoed; a write answers with zero
         if (acc)
            prdata <= pwrite ? 32'h00000000 : rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration writes land on the completing edge
   // Unused control bits are masked so reads show what is in use
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (k = 0; k < 32; k = k + 1)
            cfg_q[k] <= cfg_rst(k[3:0]);
      end else if (done & pwrite & ~pslverr & is_unit &
                   (idx < `BFD_NUM_CFG)) begin
         if (idx == `BFD_IDX_CTRL)
            cfg_q[cfg_idx] <= pwdata[15:0] & `BFD_CTRL_MASK;
         else
            cfg_q[cfg_idx] <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and level output
   // The level follows the next status value to save a cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 4'h0;
         irq_en_q   <= `BFD_IRQ_EN_RST;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         if (done & pwrite & ~pslverr & (paddr == `BFD_IRQ_EN))
            irq_en_q <= pwdata[3:0];
         irq <= |(irq_stat_d & irq_en_q);
      end
   end

endmodule // bfd_top

// >>> verification/bfd_props.sv
// Port assertions for the breaker failure block
`timescale 1ns/10ps
module bfd_props (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [1:0] three_pole_initiate_in,
   input wire logic [1:0] scheme_inhibit_in,
   input wire logic [1:0] retrip_out,
   input wire logic [1:0] zone_trip_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // Setup cycle followed by the first access cycle
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   // One wait state, then a single-cycle answer
   a_ready_one_wait: assert property (s_setup |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_unmapped: assert property (pready && paddr > 8'h88 |-> pslverr)
      else $error("no error on unmapped address");
   a_ok_mapped: assert property (pready && paddr < 8'h34 |-> !pslverr)
      else $error("error on mapped address");
   // Re-trip may only start from a live, unblocked initiate
   a_retrip_cause: assert property ($rose(retrip_out[0]) |->
      $past(three_pole_initiate_in[0]) && !$past(scheme_inhibit_in[0]))
      else $error("unit 0 re-trip without initiate");
   a_retrip_unit1: assert property ($rose(retrip_out[1]) |->
      $past(three_pole_initiate_in[1]) && !$past(scheme_inhibit_in[1]))
      else $error("unit 1 re-trip without its own initiate");
   // Inhibit drops re-trip at the next edge, seal-in included
   a_inhibit_clears: assert property (scheme_inhibit_in[0] |=>
      !retrip_out[0])
      else $error("re-trip survived inhibit");
   a_zone_needs_run: assert property ($rose(zone_trip_out[0]) |->
      retrip_out[0])
      else $error("zone trip without a running scheme");
endmodule // bfd_props
bind bfd_top bfd_props u_props (.pclk, .presetn, .psel, .penable, .paddr,
   .pready, .pslverr, .three_pole_initiate_in, .scheme_inhibit_in,
   .retrip_out, .zone_trip_out);

// >>> verification/bfd_breaker.sv
// Behavioural breaker that opens some cycles after a trip unless stuck
`timescale 1ns/10ps
module bfd_breaker (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        trip,
   input  wire logic        stuck,
   input  wire logic        reclose,
   input  wire logic [15:0] fault_amp,
   input  wire logic [7:0]  open_dly,
   output wire logic [15:0] amp,
   output wire logic        aux_closed
);
   logic [7:0] cnt_q;
   logic       open_q;
   ////////////////////////////////////////////////////////////////////////
   // Time the opening; a stuck breaker keeps carrying the fault
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 8'h00;
         open_q <= 1'b0;
      end else if (reclose) begin
         cnt_q  <= 8'h00;
         open_q <= 1'b0;
      end else if (trip && !stuck && !open_q) begin
         cnt_q  <= cnt_q + 8'h01;
         open_q <= (cnt_q >= open_dly);
      end
   end
   // Open poles carry no current; the contacts then read open
   assign amp        = open_q ? 16'h0000 : fault_amp;
   assign aux_closed = !open_q;
endmodule // bfd_breaker

// >>> verification/tb_breaker_failure_detection_logic.sv
// Self-checking bench for the dual breaker failure block
`timescale 1ns/10ps
`include "bfd_defines.vh"
module tb_breaker_failure_detection_logic;
   localparam int MS = 4; // Shortened tick keeps the run brief
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, rd_e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd_v;
   logic [1:0]  ini = 2'b00, inh = 2'b00, oos = 2'b00;
   logic [1:0]  stuck = 2'b00, rcl = 2'b00;
   logic [15:0] flt [2] = '{16'h0800, 16'h0800};
   wire  [31:0] prdata, amp;
   wire         pready, pslverr, irq;
   wire  [1:0]  retrip, zone, aux;
   int          fail_count = 0, n_checks = 0, k;
   ////////////////////////////////////////////////////////////////////////
   always #5 pclk = ~pclk;
   bfd_top #(.MS_CYCLES(MS)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .phase_amp(amp), .neutral_amp(amp),
      .three_pole_initiate_in(ini), .scheme_inhibit_in(inh),
      .fast_aux_contact_in(aux), .normal_aux_contact_in(aux),
      .out_of_service_in(oos), .retrip_out(retrip),
      .zone_trip_out(zone), .irq);
   // Unit 0 breaker opens promptly, unit 1 slowly
   for (genvar g = 0; g < 2; g++) begin : g_bkr
      bfd_breaker u_bkr (.pclk, .presetn, .trip(retrip[g]),
         .stuck(stuck[g]), .reclose(rcl[g]), .fault_amp(flt[g]),
         .open_dly(g ? 8'h10 : 8'h02), .amp(amp[16*g +: 16]),
         .aux_closed(aux[g]));
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_v    = prdata;
      rd_e    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_v);
   endtask
   function automatic logic [7:0] ra(input int u, input logic [3:0] i);
      return (u ? `BFD_UNIT1_BASE : `BFD_UNIT0_BASE) + {2'b00, i, 2'b00};
   endfunction
   // Reports whether a zone trip showed during n cycles
   task automatic watch(input int u, n, input logic e, input string nm);
      logic s;
      s = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         s = s | (zone[u] === 1'b1);
      end
      chk(nm, {31'h0, e}, {31'h0, s});
   endtask
   // Bounded wait for a zone trip to drop; k holds the cycles taken
   task automatic drop_wait(input int u);
      k = 0;
      while (zone[u] === 1'b1 && k < 200) begin
         @(posedge pclk);
         k++;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watchdog sized well beyond the expected run of several hundred cycles
   initial begin
      #200000;
      fail_count++;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ra(0, `BFD_IDX_CTRL), `BFD_CTRL_RST, "ctrl");
      rd(ra(1, `BFD_IDX_N_HI), `BFD_THR_RST, "n_hi");
      rd(ra(0, `BFD_IDX_T3), `BFD_DLY_RST, "t3");
      rd(`BFD_IRQ_EN, 32'h0, "irq_en");
      rd(8'hfc, 32'h0, "unmapped");
      chk("unmapped_err", 1, rd_e);
      for (k = 0; k < 2; k++) begin
         apb(1'b1, ra(k, `BFD_IDX_T1), 32'h3);
         apb(1'b1, ra(k, `BFD_IDX_T2), 32'h5);
         apb(1'b1, ra(k, `BFD_IDX_T3), 32'h8);
         apb(1'b1, ra(k, `BFD_IDX_HOLD), 32'h3);
      end
      apb(1'b1, `BFD_IRQ_EN, 32'hf);
      apb(1'b1, ra(0, `BFD_IDX_CTRL), 32'h7d);
      $display("test reset_setup done");
      // Healthy breaker: immediate re-trip, opens, no zone trip
      ini[0] <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("retrip", 1, retrip[0]);
      watch(0, 80, 1'b0, "zone_healthy");
      ini[0] <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("seal_release", 0, retrip[0]);
      rd(`BFD_IRQ_STAT, 32'h1, "irq_stat");
      chk("irq_on", 1, irq);
      apb(1'b1, `BFD_IRQ_CLR, 32'hf);
      repeat (2) @(posedge pclk);
      chk("irq_clear", 0, irq);
      $display("test healthy done");
      // Stuck breaker: seal holds re-trip, zone trip, then hold time
      stuck[0] <= 1'b1;
      rcl[0]   <= 1'b1;
      @(posedge pclk);
      rcl[0]   <= 1'b0;
      ini[0]   <= 1'b1;
      repeat (3) @(posedge pclk);
      ini[0]   <= 1'b0;
      watch(0, 40, 1'b1, "zone_stuck");
      chk("sealed", 1, retrip[0]);
      rd(`BFD_IRQ_STAT, 32'h5, "irq_fail");
      stuck[0] <= 1'b0;
      drop_wait(0);
      chk("hold", 1, k >= 2 * MS && k <= 5 * MS);
      $display("test stuck done");
      // Inhibit stops the scheme with initiate held
      rcl[0]   <= 1'b1;
      stuck[0] <= 1'b1;
      @(posedge pclk);
      rcl[0]   <= 1'b0;
      ini[0]   <= 1'b1;
      inh[0]   <= 1'b1;
      watch(0, 60, 1'b0, "zone_inhibit");
      chk("retrip_inhibit", 0, retrip[0]);
      // Low current refused under supervision, taken without it
      inh[0]   <= 1'b0;
      flt[0]   <= 16'h0100;
      oos[0]   <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("low_amp", 0, retrip[0]);
      apb(1'b1, ra(0, `BFD_IDX_CTRL), 32'h79);
      @(posedge pclk);
      chk("direct", 1, retrip[0]);
      watch(0, 60, 1'b0, "zone_oos");
      oos[0]   <= 1'b0;
      watch(0, 60, 1'b1, "zone_slow");
      ini[0]   <= 1'b0;
      drop_wait(0);
      $display("test inhibit_supervision done");
      // All paths off: a stuck breaker never declares failure
      flt[0]   <= 16'h0800;
      apb(1'b1, ra(0, `BFD_IDX_CTRL), 32'h0d);
      ini[0]   <= 1'b1;
      watch(0, 80, 1'b0, "zone_paths_off");
      ini[0]   <= 1'b0;
      stuck[0] <= 1'b0; // Breaker clears, so the seal-in drops
      // Second unit alone, with its interrupt masked
      apb(1'b1, `BFD_IRQ_CLR, 32'hf);
      apb(1'b1, `BFD_IRQ_EN, 32'h0);
      apb(1'b1, ra(1, `BFD_IDX_CTRL), 32'h7d);
      stuck[1] <= 1'b1;
      ini[1]   <= 1'b1;
      watch(1, 40, 1'b1, "zone_unit1");
      chk("retrip_unit0", 0, retrip[0]);
      chk("irq_masked", 0, irq);
      rd(`BFD_IRQ_STAT, 32'ha, "irq_unit1");
      $display("test unit1 done");
      // Single-pole mode drops neutral supervision, three-pole keeps it
      rcl[0]   <= 1'b1;
      apb(1'b1, ra(0, `BFD_IDX_PH_SUPV), 32'h7530);
      rcl[0]   <= 1'b0;
      apb(1'b1, ra(0, `BFD_IDX_CTRL), 32'h0f);
      ini[0]   <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("single_pole", 0, retrip[0]);
      apb(1'b1, ra(0, `BFD_IDX_CTRL), 32'h0d);
      @(posedge pclk);
      chk("three_pole_n", 1, retrip[0]);
      ini[0]   <= 1'b0;
      $display("test single_pole done");
      tally_and_finish;
   end
endmodule // tb_breaker_failure_detection_logic
